//--- flash_host_map.vh
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH

// register index
`define REG_CTRL        3'h0
`define REG_ADDR        3'h1
`define REG_WDATA       3'h2
`define REG_RDATA       3'h3
`define REG_STATUS      3'h4
`define REG_COUNT       3'h5
`define REG_BUF         3'h6

// status bits
`define ST_BUSY         0

// flash status bits
`define BIT_TOGGLE      6
`define BIT_TIMEOUT     5
`define BIT_ABORT       1

// op codes
`define OP_READ         4'h0
`define OP_PROGRAM      4'h1
`define OP_BUF_PROGRAM  4'h2
`define OP_SECT_ERASE   4'h3
`define OP_CHIP_ERASE   4'h4
`define OP_SUSPEND      4'h5
`define OP_RESUME       4'h6
`define OP_SOFT_RESET   4'h7
`define OP_HW_RESET     4'h8
`define OP_ID_LOCK      4'h9
`define OP_ID_MAKER     4'hA
`define OP_ID_SECURITY  4'hB
`define OP_ABORT_RESET  4'hC

// command cycles
`define UNLOCK_ADDR1    23'h000555
`define UNLOCK_ADDR2    23'h0002AA
`define CMD_UNLOCK1     16'h00AA
`define CMD_UNLOCK2     16'h0055
`define CMD_PROGRAM     16'h00A0
`define CMD_BUF_LOAD    16'h0025
`define CMD_BUF_CONFIRM 16'h0029
`define CMD_ERASE_SETUP 16'h0080
`define CMD_SECT_ERASE  16'h0030
`define CMD_CHIP_ERASE  16'h0010
`define CMD_SUSPEND     16'h00B0
`define CMD_RESUME      16'h0030
`define CMD_RESET       16'h00F0

// autoselect low address patterns
`define ID_LOCK_LOW     12'h002
`define ID_MAKER_LOW    12'h000
`define ID_SEC_LOW      12'h003

// timing, in the unit named
`define CLK_PERIOD_NS   20
`define GLITCH_NS       5
`define WE_PULSE_NS     40
`define ACCESS_NS       100
`define RESET_PULSE_NS  500
`define SUSPEND_US      20

`endif

//--- flash_host.v
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`include "flash_host_map.vh"
`timescale 1ns/100ps
`default_nettype none

module flash_host #(
    parameter BUF_DEPTH = 32,
    parameter BUF_AW    = 5
) (
    input  wire        i_clock,
    input  wire        i_reset,
    input  wire [2:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output wire [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    output wire        o_ce_n,
    output wire        o_we_n,
    output wire        o_oe_n,
    output wire [22:0] o_addr,
    input  wire [15:0] i_dq,
    output wire [15:0] o_dq,
    output wire        o_dq_oe,
    output wire        o_high_voltage_select_line,
    output wire        o_reset_n,
    input  wire        i_ready_busy_n
);

    localparam [7:0] S_IDLE  = 8'h01;
    localparam [7:0] S_SETUP = 8'h02;
    localparam [7:0] S_STRB  = 8'h04;
    localparam [7:0] S_HOLD  = 8'h08;
    localparam [7:0] S_NEXT  = 8'h10;
    localparam [7:0] S_WAIT  = 8'h20;
    localparam [7:0] S_HWRST = 8'h40;
    localparam [7:0] S_RDY   = 8'h80;

    // least times round up to whole cycles
    localparam WE_CYC_RAW = (`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam GL_CYC_RAW = (`GLITCH_NS + `CLK_PERIOD_NS) / `CLK_PERIOD_NS;
    localparam [15:0] WE_CYC  = (WE_CYC_RAW > GL_CYC_RAW) ? WE_CYC_RAW : GL_CYC_RAW;
    localparam [15:0] ACC_CYC = (`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [15:0] RP_CYC  = (`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [15:0] SUS_CYC = (`SUSPEND_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // number of bus cycles in each command sequence
    function [5:0] nsteps;
        input [3:0] op;
        input [4:0] cnt;
        begin
            case (op)
                `OP_PROGRAM:     nsteps = 6'd4;
                `OP_BUF_PROGRAM: nsteps = {1'b0, cnt} + 6'd6;
                `OP_SECT_ERASE:  nsteps = 6'd6;
                `OP_CHIP_ERASE:  nsteps = 6'd6;
                `OP_ABORT_RESET: nsteps = 6'd3;
                `OP_HW_RESET:    nsteps = 6'd0;
                default:         nsteps = 6'd1;
            endcase
        end
    endfunction

    // one bus cycle of a sequence: {is_write, hv, address, data}
    function [40:0] step;
        input [3:0]  op;
        input [5:0]  idx;
        input [22:0] a;
        input [15:0] wd;
        input [4:0]  cnt;
        input [15:0] bw;
        reg   [5:0]  off;
        begin
            off = idx - 6'd4;
            step = {2'b10, a, wd};
            if (idx == 6'd0 && op != `OP_READ && op != `OP_SUSPEND && op != `OP_RESUME && op != `OP_SOFT_RESET)
                step = {2'b10, `UNLOCK_ADDR1, `CMD_UNLOCK1};
            else if (idx == 6'd1)
                step = {2'b10, `UNLOCK_ADDR2, `CMD_UNLOCK2};
            case (op)
                `OP_READ:        step = {2'b00, a, 16'h0000};
                `OP_PROGRAM: begin
                    if (idx == 6'd2)
                        step = {2'b10, `UNLOCK_ADDR1, `CMD_PROGRAM};
                    else if (idx == 6'd3)
                        step = {2'b10, a, wd};
                end
                `OP_BUF_PROGRAM: begin
                    if (idx == 6'd2)
                        step = {2'b10, a, `CMD_BUF_LOAD};
                    else if (idx == 6'd3)
                        step = {2'b10, a, {11'h000, cnt}};
                    else if (idx == {1'b0, cnt} + 6'd5)
                        step = {2'b10, a, `CMD_BUF_CONFIRM};
                    else if (idx > 6'd3)
                        step = {2'b10, a + {17'h00000, off}, bw};
                end
                `OP_SECT_ERASE, `OP_CHIP_ERASE: begin
                    if (idx == 6'd2 || idx == 6'd3)
                        step = {2'b10, `UNLOCK_ADDR1, (idx == 6'd2) ? `CMD_ERASE_SETUP : `CMD_UNLOCK1};
                    else if (idx == 6'd4)
                        step = {2'b10, `UNLOCK_ADDR2, `CMD_UNLOCK2};
                    else if (idx == 6'd5)
                        step = (op == `OP_SECT_ERASE) ? {2'b10, a, `CMD_SECT_ERASE}
                                                      : {2'b10, `UNLOCK_ADDR1, `CMD_CHIP_ERASE};
                end
                `OP_SUSPEND:     step = {2'b10, a, `CMD_SUSPEND};
                `OP_RESUME:      step = {2'b10, a, `CMD_RESUME};
                `OP_SOFT_RESET:  step = {2'b10, a, `CMD_RESET};
                `OP_ABORT_RESET: if (idx == 6'd2) step = {2'b10, `UNLOCK_ADDR1, `CMD_RESET};
                `OP_ID_LOCK:     step = {2'b01, a[22:12], `ID_LOCK_LOW, 16'h0000};
                `OP_ID_MAKER:    step = {2'b01, 11'h000, `ID_MAKER_LOW, 16'h0000};
                `OP_ID_SECURITY: step = {2'b01, 11'h000, `ID_SEC_LOW, 16'h0000};
                default:         step = {2'b00, a, 16'h0000};
            endcase
        end
    endfunction

    reg         wait_q;
    reg  [31:0] rdmux_q;
    reg  [22:0] areg_q;
    reg  [15:0] wreg_q;
    reg  [4:0]  creg_q;
    reg  [BUF_AW-1:0] bwp_q;
    reg  [15:0] buf_mem [0:BUF_DEPTH-1];
    reg  [7:0]  st_q;
    reg  [3:0]  op_q;
    reg  [5:0]  idx_q;
    reg  [15:0] cnt_q;
    reg  [1:0]  pstate_q;
    reg         pphase_q;
    reg  [15:0] prev_q;
    reg  [15:0] rdata_q;
    reg         busy_q;
    reg         done_q;
    reg         err_to_q;
    reg         err_ab_q;
    reg         susp_q;
    reg         cur_wr_q;
    reg         ce_n_q;
    reg         we_n_q;
    reg         oe_n_q;
    reg  [22:0] addr_q;
    reg  [15:0] dq_q;
    reg         dq_oe_q;
    reg         hv_q;
    reg         rst_n_q;
    reg         rb_meta_q;
    reg         rb_q;

    wire        acc_ok = !wait_q;
    wire        wr_ok  = i_avs_write && acc_ok;
    wire        start  = wr_ok && i_avs_address == `REG_CTRL && !busy_q;
    wire [5:0]  boff   = idx_q - 6'd4;
    wire [40:0] cur_step = step(op_q, idx_q, areg_q, wreg_q, creg_q, buf_mem[boff[BUF_AW-1:0]]);
    wire [5:0]  nst    = nsteps(op_q, creg_q);
    wire        needs_poll = (op_q == `OP_PROGRAM) || (op_q == `OP_BUF_PROGRAM) ||
                             (op_q == `OP_SECT_ERASE) || (op_q == `OP_CHIP_ERASE);
    wire [15:0] status = {10'h000, rb_q, susp_q, err_ab_q, err_to_q, done_q, busy_q};

    // avalon slave: every access answers on the second edge
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            wait_q  <= 1'b1;
            rdmux_q <= 32'h00000000;
        end else begin
            wait_q <= !((i_avs_read || i_avs_write) && wait_q);
            if (i_avs_read && wait_q) begin
                case (i_avs_address)
                    `REG_CTRL:   rdmux_q <= {28'h0000000, op_q};
                    `REG_ADDR:   rdmux_q <= {9'h000, areg_q};
                    `REG_WDATA:  rdmux_q <= {16'h0000, wreg_q};
                    `REG_RDATA:  rdmux_q <= {16'h0000, rdata_q};
                    `REG_STATUS: rdmux_q <= {16'h0000, status};
                    `REG_COUNT:  rdmux_q <= {27'h0000000, creg_q};
                    `REG_BUF:    rdmux_q <= {{(32-BUF_AW){1'b0}}, bwp_q};
                    default:     rdmux_q <= 32'h00000000;
                endcase
            end
        end
    end

    // setup registers; changes are refused while an operation runs
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            areg_q <= 23'h000000;
            wreg_q <= 16'h0000;
            creg_q <= 5'h00;
            bwp_q  <= {BUF_AW{1'b0}};
        end else if (wr_ok && !busy_q) begin
            case (i_avs_address)
                `REG_ADDR:  areg_q <= i_avs_writedata[22:0];
                `REG_WDATA: wreg_q <= i_avs_writedata[15:0];
                `REG_COUNT: creg_q <= i_avs_writedata[4:0];
                `REG_BUF:   bwp_q  <= bwp_q + {{(BUF_AW-1){1'b0}}, 1'b1};
                `REG_CTRL:  if (i_avs_writedata[3:0] == `OP_BUF_PROGRAM) bwp_q <= {BUF_AW{1'b0}};
                default:    bwp_q <= bwp_q;
            endcase
        end
    end

    // buffer words, no reset needed on storage
    always @(posedge i_clock) begin
        if (wr_ok && !busy_q && i_avs_address == `REG_BUF)
            buf_mem[bwp_q] <= i_avs_writedata[15:0];
    end

    // ready_busy_n crosses in through two flops
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            rb_meta_q <= 1'b0;
            rb_q      <= 1'b0;
        end else begin
            rb_meta_q <= i_ready_busy_n;
            rb_q      <= rb_meta_q;
        end
    end

    // sequencer and flash bus engine; strobes idle high from reset
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            st_q     <= S_IDLE;
            op_q     <= `OP_READ;
            idx_q    <= 6'd0;
            cnt_q    <= 16'h0000;
            pstate_q <= 2'd0;
            pphase_q <= 1'b0;
            prev_q   <= 16'h0000;
            rdata_q  <= 16'h0000;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            err_to_q <= 1'b0;
            err_ab_q <= 1'b0;
            susp_q   <= 1'b0;
            cur_wr_q <= 1'b0;
            ce_n_q   <= 1'b1;
            we_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            addr_q   <= 23'h000000;
            dq_q     <= 16'h0000;
            dq_oe_q  <= 1'b0;
            hv_q     <= 1'b0;
            rst_n_q  <= 1'b1;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (start) begin
                        // orders taken only while idle
                        op_q     <= i_avs_writedata[3:0];
                        idx_q    <= 6'd0;
                        pstate_q <= 2'd0;
                        pphase_q <= 1'b0;
                        busy_q   <= 1'b1;
                        done_q   <= 1'b0;
                        err_to_q <= 1'b0;
                        err_ab_q <= 1'b0;
                        if (i_avs_writedata[3:0] == `OP_HW_RESET) begin
                            rst_n_q <= 1'b0;
                            cnt_q   <= RP_CYC;
                            st_q    <= S_HWRST;
                        end else begin
                            st_q <= S_NEXT;
                        end
                    end
                end
                S_NEXT: begin
                    if (pstate_q == 2'd1 || (idx_q == nst && needs_poll && pstate_q == 2'd0)) begin
                        // status reads go to the target address
                        pstate_q <= 2'd1;
                        cur_wr_q <= 1'b0;
                        addr_q   <= areg_q;
                        hv_q     <= 1'b0;
                        ce_n_q   <= 1'b0;
                        st_q     <= S_SETUP;
                    end else if (idx_q < nst) begin
                        // whole sequence issued back to back, never cut short
                        cur_wr_q <= cur_step[40];
                        hv_q     <= cur_step[39];
                        addr_q   <= cur_step[38:16];
                        dq_q     <= cur_step[15:0];
                        dq_oe_q  <= cur_step[40];
                        ce_n_q   <= 1'b0;
                        idx_q    <= idx_q + 6'd1;
                        st_q     <= S_SETUP;
                    end else if (op_q == `OP_SUSPEND && cnt_q == 16'h0000) begin
                        cnt_q <= SUS_CYC;
                        st_q  <= S_WAIT;
                    end else begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        if (op_q == `OP_SUSPEND)
                            susp_q <= 1'b1;
                        else if (op_q == `OP_RESUME || op_q == `OP_SOFT_RESET || op_q == `OP_ABORT_RESET)
                            susp_q <= 1'b0;
                        cnt_q <= 16'h0000;
                        st_q  <= S_IDLE;
                    end
                end
                S_SETUP: begin
                    // write needs oe high; read needs we high
                    we_n_q <= !cur_wr_q;
                    oe_n_q <= cur_wr_q;
                    cnt_q  <= cur_wr_q ? WE_CYC : ACC_CYC;
                    st_q   <= S_STRB;
                end
                S_STRB: begin
                    if (cnt_q == 16'h0001) begin
                        if (!cur_wr_q)
                            rdata_q <= i_dq;
                        we_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        cnt_q  <= 16'h0000;
                        st_q   <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_HOLD: begin
                    ce_n_q  <= 1'b1;
                    dq_oe_q <= 1'b0;
                    hv_q    <= 1'b0;
                    st_q    <= S_NEXT;
                    if (pstate_q == 2'd1) begin
                        pphase_q <= !pphase_q;
                        prev_q   <= rdata_q;
                        if (pphase_q) begin
                            // steady toggle bit: embedded work ended
                            if (prev_q[`BIT_TOGGLE] == rdata_q[`BIT_TOGGLE]) begin
                                pstate_q <= 2'd2;
                            end else if (prev_q[`BIT_TIMEOUT] && rdata_q[`BIT_TIMEOUT]) begin
                                err_to_q <= 1'b1;
                                op_q     <= `OP_SOFT_RESET;
                                idx_q    <= 6'd0;
                                pstate_q <= 2'd0;
                            end else if (op_q == `OP_BUF_PROGRAM && rdata_q[`BIT_ABORT]) begin
                                err_ab_q <= 1'b1;
                                op_q     <= `OP_ABORT_RESET;
                                idx_q    <= 6'd0;
                                pstate_q <= 2'd0;
                            end
                        end
                    end
                end
                S_WAIT: begin
                    if (cnt_q == 16'h0001)
                        st_q <= S_NEXT;
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                S_HWRST: begin
                    if (cnt_q == 16'h0001) begin
                        rst_n_q <= 1'b1;
                        st_q    <= S_RDY;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                S_RDY: begin
                    // busy line stays low until read mode is back
                    if (rb_q) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                        susp_q <= 1'b0;
                        st_q   <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign o_avs_readdata             = rdmux_q;
    assign o_avs_waitrequest          = wait_q;
    assign o_ce_n                     = ce_n_q;
    assign o_we_n                     = we_n_q;
    assign o_oe_n                     = oe_n_q;
    assign o_addr                     = addr_q;
    assign o_dq                       = dq_q;
    assign o_dq_oe                    = dq_oe_q;
    assign o_high_voltage_select_line = hv_q;
    assign o_reset_n                  = rst_n_q;

endmodule

`default_nettype wire

//--- flash_host_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module flash_host_assertions (
    input wire        i_clock,
    input wire        i_reset,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire        o_avs_waitrequest,
    input wire        o_ce_n,
    input wire        o_we_n,
    input wire        o_oe_n,
    input wire [22:0] o_addr,
    input wire [15:0] o_dq,
    input wire        o_dq_oe,
    input wire        o_high_voltage_select_line,
    input wire        o_reset_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // one wait cycle, answer one cycle
    wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer");
    answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("long answer");
    write_qual_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
        else $error("bad write qualifiers");
    // well above the glitch floor
    we_width_a: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
        else $error("write width");
    latch_hold_a: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq))
        else $error("moved under strobe");
    read_width_a: assert property ($fell(o_oe_n) |=> !o_oe_n [*4] ##1 o_oe_n)
        else $error("read width");
    no_clash_a: assert property (!o_oe_n |-> !o_dq_oe && !o_ce_n)
        else $error("bus clash");
    // select line only on reads, fixed low address
    hv_read_a: assert property (o_high_voltage_select_line |-> o_we_n && !o_dq_oe)
        else $error("select on write");
    hv_addr_a: assert property (o_high_voltage_select_line && !o_oe_n |-> o_addr[6] == 1'b0 && o_addr[3:2] == 2'b00)
        else $error("bad id address");
    reset_len_a: assert property ($fell(o_reset_n) |=> !o_reset_n [*8])
        else $error("short reset");
    cover property ($rose(o_high_voltage_select_line));
    cover property ($fell(o_reset_n));
    cover property ($fell(o_we_n));
endmodule
bind flash_host flash_host_assertions chk (.i_clock(i_clock), .i_reset(i_reset), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
    .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_high_voltage_select_line(o_high_voltage_select_line), .o_reset_n(o_reset_n));
`default_nettype wire

//--- flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
    parameter int         BUSY_CYC = 30,
    parameter logic [7:0] MAKER_ID = 8'h5A
) (
    input  wire logic        i_clock,
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_hv,
    input  wire logic        i_reset_n,
    input  wire logic [22:0] i_addr,
    input  wire logic [15:0] i_dq,
    output logic      [15:0] o_q,
    output logic             o_ready_busy_n
);
    logic [15:0] mem [0:255];
    logic [22:0] wa;
    logic [6:0]  sect;
    logic [17:0] page;
    logic [15:0] last = 16'h0;
    logic [15:0] q = 16'h0;
    logic        abort = 1'b0;
    logic        tog = 1'b0;
    int          ph = 0;
    int          n;
    int          left;
    int          busy = 0;
    realtime     t0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // address taken on the falling strobe
    always @(negedge i_we_n) begin
        wa = i_addr;
        t0 = $realtime;
    end
    // decode on rising strobe; loads go straight to array
    always @(posedge i_we_n) if (!i_ce_n && i_oe_n && i_reset_n && busy == 0 && $realtime - t0 >= 5.0) begin
        case (ph)
            0: ph = (i_dq == 16'h00AA && wa[11:0] == 12'h555) ? 1 : 0;
            1: ph = (i_dq == 16'h0055 && wa[11:0] == 12'h2AA) ? 2 : 0;
            2: begin
                ph = abort ? 0 : i_dq == 16'h00A0 ? 3 : i_dq == 16'h0025 ? 4 : 0;
                if (i_dq == 16'h00F0) abort = 1'b0;
                sect = wa[22:16];
            end
            3: begin
                mem[wa[7:0]] = mem[wa[7:0]] & i_dq;
                last = i_dq;
                busy = BUSY_CYC;
                ph = 0;
            end
            4: begin
                left = i_dq;
                n = 0;
                abort = i_dq > 16'd31 || wa[22:16] != sect;
                ph = abort ? 0 : 5;
            end
            5: begin
                if (n == 0) page = wa[22:5];
                abort = wa[22:16] != sect || wa[22:5] != page;
                if (!abort) mem[wa[7:0]] = mem[wa[7:0]] & i_dq;
                last = i_dq;
                n++;
                ph = abort ? 0 : n > left ? 6 : 5;
            end
            default: begin
                abort = i_dq != 16'h0029;
                busy = abort ? 0 : BUSY_CYC;
                ph = 0;
            end
        endcase
    end
    // status, id or array
    always @(negedge i_oe_n) if (!i_ce_n) begin
        tog = ~tog;
        if (busy > 0 || abort) q = {8'h00, ~last[7], tog, 4'h0, abort, 1'b0};
        else if (i_hv) q = i_addr[1:0] == 2'b00 ? {8'h00, MAKER_ID} :
            i_addr[1:0] == 2'b11 ? 16'h0099 : {15'h0, i_addr[12]};
        else q = mem[i_addr[7:0]];
    end
    // released bus shows inverse
    assign o_q = (!i_oe_n && !i_ce_n) ? q : ~q;
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy = 4;
            abort = 1'b0;
            ph = 0;
        end else if (busy > 0) busy = busy - 1;
    end
    assign o_ready_busy_n = busy == 0;
endmodule
`default_nettype wire

//--- test_flash_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_map.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_flash_host;
    localparam logic [7:0] MAKER_ID = 8'h5A; // arbitrary value
    logic        i_clock = 1'b0;
    logic        i_reset = 1'b1;
    logic [2:0]  i_avs_address = 3'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic        do_chk = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] got, ev;
    logic [31:0] exp_q[$];
    string       name_q[$], nm;
    logic [15:0] emem [0:255];
    logic [15:0] rnd = 16'h0037;
    int          checks = 0, fail_count = 0;
    wire  [31:0] o_avs_readdata;
    wire  [22:0] o_addr;
    wire  [15:0] o_dq, m_q, dq_bus;
    wire         o_avs_waitrequest, o_ce_n, o_we_n, o_oe_n, o_dq_oe, o_hv, o_reset_n, ready_busy_n;
    logic [3:0]  ops [7] = '{`OP_SECT_ERASE, `OP_CHIP_ERASE, `OP_SUSPEND, `OP_RESUME, `OP_SOFT_RESET, `OP_HW_RESET,
                             `OP_ABORT_RESET};
    logic [7:0]  stx [7] = '{8'h22, 8'h22, 8'h32, 8'h22, 8'h22, 8'h22, 8'h22};
    logic [3:0]  id_op [4] = '{`OP_ID_LOCK, `OP_ID_LOCK, `OP_ID_MAKER, `OP_ID_SECURITY};
    logic [7:0]  id_x [4] = '{8'h00, 8'h01, MAKER_ID, 8'h99};
    always #10 i_clock = ~i_clock;
    flash_host uut (.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr),
        .i_dq(dq_bus), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_high_voltage_select_line(o_hv), .o_reset_n(o_reset_n),
        .i_ready_busy_n(ready_busy_n));
    flash_model #(.MAKER_ID(MAKER_ID)) model (.i_clock(i_clock), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
        .i_hv(o_hv), .i_reset_n(o_reset_n), .i_addr(o_addr), .i_dq(dq_bus), .o_q(m_q), .o_ready_busy_n(ready_busy_n));
    assign dq_bus = o_dq_oe ? o_dq : m_q;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // one transfer, edge gap first
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d, input logic chk);
        int n;
        n = 0;
        @(posedge i_clock);
        {i_avs_address, i_avs_writedata, i_avs_write, i_avs_read, do_chk} <= {a, d, wr, !wr, chk};
        do begin @(posedge i_clock); n++; end while (o_avs_waitrequest !== 1'b0 && n < 50);
        got = o_avs_readdata;
        {i_avs_write, i_avs_read, do_chk} <= 3'b000;
        if (n == 50) begin fail_count++; close_out(); end
    endtask
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e, input string s);
        name_q.push_back(s);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 1'b1);
    endtask
    // start op, poll idle
    task automatic run(input logic [3:0] op);
        int k;
        k = 0;
        wr(`REG_CTRL, {28'h0, op});
        do begin bus(1'b0, `REG_STATUS, 32'h0, 1'b0); k++; end while (got[`ST_BUSY] !== 1'b0 && k < 2000);
        if (k == 2000) begin fail_count++; close_out(); end
    endtask
    task automatic prog(input logic [22:0] a, input logic [15:0] d);
        wr(`REG_ADDR, {9'h0, a});
        wr(`REG_WDATA, {16'h0, d});
        emem[a[7:0]] = emem[a[7:0]] & d;
        run(`OP_PROGRAM);
        rd(`REG_RDATA, {16'h0, emem[a[7:0]]}, "program");
    endtask
    task automatic reset_run(input string s);
        i_reset <= 1'b1;
        repeat (10) @(posedge i_clock);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clock); // ready sync needs two edges
        rd(`REG_STATUS, 32'h20, s);
    endtask
    // oldest note vs read answer
    always @(posedge i_clock) if (i_avs_read && do_chk && o_avs_waitrequest === 1'b0) begin
        nm = name_q.pop_front();
        ev = exp_q.pop_front();
        `CHK(nm, ev, o_avs_readdata)
    end
    initial begin
        foreach (emem[i]) emem[i] = 16'hFFFF;
        reset_run("reset");
        wr(3'h7, 32'hFFFF);
        rd(3'h7, 32'h0, "unmapped");
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            prog(23'h000010, rnd);
        end
        // good buffer, then one crossing a page boundary
        for (int j = 0; j < 2; j++) begin
            wr(`REG_ADDR, j ? 32'h1E : 32'h40);
            wr(`REG_COUNT, 32'h3);
            for (int i = 0; i < 4; i++) begin
                rnd = lfsr(rnd);
                if (!j) emem[8'h40 + i] = emem[8'h40 + i] & rnd;
                wr(`REG_BUF, {16'h0, rnd});
            end
            rd(`REG_BUF, 32'h4, "buf ptr");
            run(`OP_BUF_PROGRAM);
            rd(`REG_STATUS, j ? 32'h2A : 32'h22, "buf status");
        end
        prog(23'h000011, 16'h1234);
        wr(`REG_ADDR, 32'h42);
        run(`OP_READ);
        rd(`REG_RDATA, {16'h0, emem[8'h42]}, "buf word");
        foreach (id_op[i]) begin
            wr(`REG_ADDR, i == 1 ? 32'h1000 : 32'h0);
            run(id_op[i]);
            rd(`REG_RDATA, {24'h0, id_x[i]}, "id");
        end
        foreach (ops[i]) begin
            run(ops[i]);
            rd(`REG_STATUS, {24'h0, stx[i]}, "op status");
        end
        reset_run("second reset");
        close_out();
    end
endmodule
`default_nettype wire
